// File: common/tcm_pkg.sv
// constants and carriers for the type-c port data mux control block
// assumes one 10 MHz core clock and an ahb-lite register port
package tcm_pkg;
   // ===================================================
   // register byte offsets
   localparam logic [7:0] OFS_CTRL  = 8'h00;
   localparam logic [7:0] OFS_SEL   = 8'h04;
   localparam logic [7:0] OFS_XBAR  = 8'h08;
   localparam logic [7:0] OFS_PULL  = 8'h0C;
   localparam logic [7:0] OFS_CMPEN = 8'h10;
   localparam logic [7:0] OFS_STAT  = 8'h14;
   localparam logic [7:0] OFS_INFO  = 8'h18;
   // ===================================================
   // field positions
   localparam int CTRL_XBAR_EN   = 0;
   localparam int CTRL_EP_EN     = 1;
   localparam int CTRL_DCD_EN    = 2;
   localparam int CTRL_LS_ANALOG = 3;
   localparam int SEL_TOP_LSB    = 0;
   localparam int SEL_BOT_LSB    = 4;
   localparam int SEL_SBU_LSB    = 8;
   localparam int XBAR_DIR_LSB   = 8;
   localparam int PULL_DN_LSB    = 8;
   localparam int STAT_LVL_LSB   = 8;
   localparam int INFO_RATE_LSB  = 8;
   // ===================================================
   // reset values and fixed figures
   localparam logic [31:0] CTRL_RST  = 32'h0000_0000;
   localparam logic [31:0] XBAR_RST  = 32'h0000_3F3F;
   localparam logic [7:0]  BB_CLASS  = 8'h11;
   localparam logic [15:0] EP_KBPS   = 16'h05DC;
   localparam logic [1:0]  PAIR_NONE = 2'h3;
   // ===================================================
   // first-stage source codes
   typedef enum logic [2:0] {
      SRC_NONE = 3'h0, SRC_ROOT = 3'h1, SRC_EP   = 3'h2, SRC_SWD  = 3'h3,
      SRC_DBGA = 3'h4, SRC_DBGB = 3'h5, SRC_AUX  = 3'h6, SRC_UART = 3'h7
   } tcm_src_e;
   // switch closures per connector position, one bit per source code
   typedef struct packed {
      logic       sbu_swap;
      logic [7:0] sbu;
      logic [7:0] bot;
      logic [7:0] top;
   } tcm_sw_s;
endpackage : tcm_pkg

// File: core/tcm_port_mux_ctrl.sv
// control logic for the type-c port data multiplexer: switch steering,
// uart crossbar, change comparators, pulls, clamps and endpoint/dcd switching
// assumes an ahb-lite master on core_clk and analog switches driven by the outputs
// Contract
// - top and bottom d+/d- pairs swap with cable orientation
// - sideband crossbar swaps its two pins when cable reversed
// - pair mapping fixed; debug, swd and aux may also use sideband
// - uart0 top pair, uart1 bottom pair, uart2 sideband; tx on first pin
// - firmware routes uart, lowspeed and general pins to any channel
// - each crossbar pin individually set as input or output
// - after reset system uart rx is buffered onto system uart tx
// - uart paths buffered with tri-state; lowspeed pair may be analog
// - enabled port-input comparators interrupt the core on a change
// - each port output has its own pull-up and pull-down select
// - a pin is clamped only while a second-stage path is closed
// - endpoint runs only at low speed 1.5 mbps, endpoint zero
// - endpoint zero advertises the billboard class
// - endpoint drives the lines of the selected connector pair
// - low-speed pull-up is off while transmitting
// - in receive the pull-up sits on the orientation-selected d-
// - data contact detect sources current into selected d+
// - data contact detect pulls the selected d- down
// - charger detection elements are switched into the port mux
//
// The AHB-Lite slave port and the register addresses were decided locally.
`timescale 1ns/1ns
`default_nettype none
module tcm_port_mux_ctrl
   import tcm_pkg::*;
(
   input  wire logic        core_clk,
   input  wire logic        rstn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic [31:0]      hrdata,
   output logic             hresp,
   input  wire logic        orient_flip_pin,
   input  wire logic        ep_transmit,
   input  wire logic [5:0]  port_pin_in,
   input  wire logic [5:0]  xb_pin_in,
   output logic [5:0]       xb_pin_out,
   output logic [5:0]       xb_pin_oe,
   input  wire logic [2:0]  core_serial_in,
   output logic [2:0]       core_serial_out,
   output tcm_sw_s          sw,
   output logic [5:0]       clamp_en,
   output logic [5:0]       pull_up,
   output logic [5:0]       pull_dn,
   output logic [5:0]       cmp_en,
   output logic [1:0]       lowspeed_pullup,
   output logic [1:0]       ep_drive,
   output logic [1:0]       dcd_dplus_current,
   output logic [1:0]       dcd_dminus_pulldown,
   output logic             ls_analog,
   output logic             core_irq
);
   // port pin order: 0 top d+, 1 top d-, 2 bottom d+, 3 bottom d-, 4 sideband a, 5 sideband b
   // crossbar pin order: 0 sys serial rx, 1 sys serial tx, 2 lowspeed_port_to_host,
   // 3 lowspeed_host_to_port, 4 general_pin_one, 5 general_pin_two; pair k = pins 2k, 2k+1

   function automatic logic [7:0] dec_src(input logic [2:0] code, input logic sbu_pos);
      logic [7:0] v;
      v = 8'h01 << code;
      v[0] = 1'b0;
      if (sbu_pos) begin
         v[SRC_ROOT] = 1'b0;
         v[SRC_EP]   = 1'b0;
      end
      return v;
   endfunction : dec_src

   // ===================================================
   // ahb-lite slave, zero wait states
   logic        ph_wr_q;
   logic [7:0]  ph_addr_q;
   logic [31:0] ctrl_q, sel_q, xbar_q, pull_q, cmpen_q;
   logic [5:0]  flag_q;
   logic [5:0]  lvl_q;
   logic        acc;
   logic [31:0] rd_d;

   assign acc = hsel && hready && htrans[1];

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         ph_wr_q   <= 1'b0;
         ph_addr_q <= 8'h00;
         hreadyout <= 1'b0;
         hresp     <= 1'b0;
      end else begin
         ph_wr_q   <= acc && hwrite;
         ph_addr_q <= haddr[7:0];
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
   end

   always_comb begin
      rd_d = 32'h0000_0000;
      unique case (haddr[7:0])
         OFS_CTRL:  rd_d = ctrl_q;
         OFS_SEL:   rd_d = sel_q;
         OFS_XBAR:  rd_d = xbar_q;
         OFS_PULL:  rd_d = pull_q;
         OFS_CMPEN: rd_d = cmpen_q;
         OFS_STAT:  rd_d = {18'h0, lvl_q, 2'h0, flag_q};
         OFS_INFO:  rd_d = {8'h00, EP_KBPS, BB_CLASS};
         default:   rd_d = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (!rstn) hrdata <= 32'h0000_0000;
      else if (acc && !hwrite) hrdata <= rd_d;
   end

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         ctrl_q  <= CTRL_RST;
         sel_q   <= 32'h0000_0000;
         xbar_q  <= XBAR_RST;
         pull_q  <= 32'h0000_0000;
         cmpen_q <= 32'h0000_0000;
      end else if (ph_wr_q) begin
         if (ph_addr_q == OFS_CTRL)  ctrl_q  <= {28'h0, hwdata[3:0]};
         if (ph_addr_q == OFS_SEL)   sel_q   <= {21'h0, hwdata[10:8], 1'b0, hwdata[6:4], 1'b0, hwdata[2:0]};
         if (ph_addr_q == OFS_XBAR)  xbar_q  <= {18'h0, hwdata[13:8], 2'h0, hwdata[5:0]};
         if (ph_addr_q == OFS_PULL)  pull_q  <= {18'h0, hwdata[13:8], 2'h0, hwdata[5:0]};
         if (ph_addr_q == OFS_CMPEN) cmpen_q <= {26'h0, hwdata[5:0]};
      end
   end

   // ===================================================
   // input synchronisers
   logic       orient_s1, orient_s2, orient_q;
   logic [5:0] port_s1, port_s2, xb_s1, xb_s2;
   logic [2:0] cser_s1, cser_s2;

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         orient_s1 <= 1'b0;
         orient_s2 <= 1'b0;
         orient_q  <= 1'b0;
         port_s1   <= 6'h00;
         port_s2   <= 6'h00;
         xb_s1     <= 6'h00;
         xb_s2     <= 6'h00;
         cser_s1   <= 3'h0;
         cser_s2   <= 3'h0;
      end else begin
         orient_s1 <= orient_flip_pin;
         orient_s2 <= orient_s1;
         orient_q  <= orient_s2;
         port_s1   <= port_pin_in;
         port_s2   <= port_s1;
         xb_s1     <= xb_pin_in;
         xb_s2     <= xb_s1;
         cser_s1   <= core_serial_in;
         cser_s2   <= cser_s1;
      end
   end

   // ===================================================
   // second-stage steering; everything derives from orient_q in one edge
   logic [7:0] top_v, bot_v, sbu_v;
   logic       ep_top, ep_bot, ep_rx;

   assign top_v = dec_src(orient_q ? sel_q[SEL_BOT_LSB +: 3] : sel_q[SEL_TOP_LSB +: 3], 1'b0);
   assign bot_v = dec_src(orient_q ? sel_q[SEL_TOP_LSB +: 3] : sel_q[SEL_BOT_LSB +: 3], 1'b0);
   assign sbu_v = dec_src(sel_q[SEL_SBU_LSB +: 3], 1'b1);
   assign ep_top = top_v[SRC_EP];
   assign ep_bot = bot_v[SRC_EP];
   assign ep_rx  = ctrl_q[CTRL_EP_EN] && !ep_transmit;

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         sw                  <= '0;
         clamp_en            <= 6'h00;
         ep_drive            <= 2'h0;
         lowspeed_pullup     <= 2'h0;
         dcd_dplus_current   <= 2'h0;
         dcd_dminus_pulldown <= 2'h0;
      end else begin
         sw.top      <= top_v;
         sw.bot      <= bot_v;
         sw.sbu      <= sbu_v;
         sw.sbu_swap <= orient_q;
         clamp_en    <= {{2{|sbu_v}}, {2{|bot_v}}, {2{|top_v}}};
         ep_drive    <= {ep_bot, ep_top} & {2{ctrl_q[CTRL_EP_EN] && ep_transmit}};
         lowspeed_pullup <= {orient_q, !orient_q} & {2{ep_rx}};
         dcd_dplus_current   <= {orient_q, !orient_q} & {2{ctrl_q[CTRL_DCD_EN]}};
         dcd_dminus_pulldown <= {orient_q, !orient_q} & {2{ctrl_q[CTRL_DCD_EN]}};
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         pull_up <= 6'h00;
         pull_dn <= 6'h00;
      end else begin
         pull_up <= pull_q[5:0];
         pull_dn <= pull_q[PULL_DN_LSB +: 6];
      end
   end

   // ===================================================
   // digital uart crossbar; channel n feeds the uart source of its fixed pair
   logic [5:0] dir;
   logic [5:0] xo_d, xoe_d;
   logic [2:0] cso_d;
   logic [1:0] pr;

   assign dir = xbar_q[XBAR_DIR_LSB +: 6];

   always_comb begin
      xo_d  = 6'h00;
      xoe_d = 6'h00;
      cso_d = 3'h0;
      pr    = 2'h0;
      for (int n = 0; n < 3; n++) begin
         pr = xbar_q[2*n +: 2];
         if (pr != PAIR_NONE) begin
            // tx toward port comes from the pin of the pair set as input
            cso_d[n] = dir[2*pr] ? xb_s2[2*pr+1] : xb_s2[2*pr];
            xo_d[2*pr]   = cser_s2[n];
            xo_d[2*pr+1] = cser_s2[n];
            xoe_d[2*pr]   = dir[2*pr];
            xoe_d[2*pr+1] = dir[2*pr+1];
         end
      end
      if (!ctrl_q[CTRL_XBAR_EN]) begin
         // daisy-chain bypass until firmware takes the crossbar over
         xo_d  = {4'h0, xb_s2[0], 1'b0};
         xoe_d = 6'h02;
         cso_d = 3'h0;
      end
      if (ctrl_q[CTRL_LS_ANALOG]) xoe_d[3:2] = 2'h0;
   end

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         xb_pin_out      <= 6'h00;
         xb_pin_oe       <= 6'h00;
         core_serial_out <= 3'h0;
         ls_analog       <= 1'b0;
      end else begin
         xb_pin_out      <= xo_d;
         xb_pin_oe       <= xoe_d;
         core_serial_out <= cso_d;
         ls_analog       <= ctrl_q[CTRL_LS_ANALOG];
      end
   end

   // ===================================================
   // change comparators; a new edge beats a same-cycle clear
   logic [5:0] evt, w1c;

   assign evt = (port_s2 ^ lvl_q) & cmpen_q[5:0];
   assign w1c = (ph_wr_q && ph_addr_q == OFS_STAT) ? hwdata[5:0] : 6'h00;

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         lvl_q    <= 6'h00;
         flag_q   <= 6'h00;
         cmp_en   <= 6'h00;
         core_irq <= 1'b0;
      end else begin
         lvl_q    <= port_s2;
         flag_q   <= (flag_q & ~w1c) | evt;
         cmp_en   <= cmpen_q[5:0];
         core_irq <= |((flag_q & ~w1c) | evt);
      end
   end

   // ===================================================
   // checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstn);

   sequence s_ctrl_wr;
      acc && hwrite && haddr[7:0] == OFS_CTRL ##1 1'b1;
   endsequence

   a_ctrl_write: assert property (s_ctrl_wr |=> ctrl_q[3:0] == $past(hwdata[3:0]))
      else $error("ctrl write not stored");
   a_pair_swap: assert property ($past(orient_q) && $stable(sel_q) |->
      sw.top == dec_src(sel_q[SEL_BOT_LSB +: 3], 1'b0))
      else $error("top pair not swapped");
   a_sbu_swap: assert property (sw.sbu_swap == $past(orient_q))
      else $error("sideband swap lags orientation");
   a_sbu_legal: assert property (!sw.sbu[SRC_ROOT] && !sw.sbu[SRC_EP])
      else $error("usb source on sideband");
   a_bypass_path: assert property (!ctrl_q[CTRL_XBAR_EN] && !ctrl_q[CTRL_LS_ANALOG] |=>
      xb_pin_oe == 6'h02 && xb_pin_out[1] == $past(xb_s2[0]))
      else $error("bypass not driven");
   a_clamp_path: assert property (clamp_en[0] == |sw.top && clamp_en[4] == |sw.sbu)
      else $error("clamp without path");
   a_pullup_tx: assert property (ep_transmit |=> lowspeed_pullup == 2'h0)
      else $error("pull-up on while transmitting");
   a_pullup_side: assert property (ctrl_q[CTRL_EP_EN] && !ep_transmit && $stable(orient_q) |=>
      lowspeed_pullup == {$past(orient_q), !$past(orient_q)})
      else $error("pull-up on wrong d-");
   a_dcd_pair: assert property (dcd_dplus_current == dcd_dminus_pulldown &&
      dcd_dplus_current != 2'h3)
      else $error("dcd elements split");
   a_flag_set: assert property (evt[0] |=> flag_q[0] && core_irq)
      else $error("change not flagged");

   // ===================================================
   // gating and mirror checks; each output lags its source by one edge
   sequence s_ep_tx;
      ctrl_q[CTRL_EP_EN] && ep_transmit;
   endsequence

   a_ep_drive: assert property (s_ep_tx |=> ep_drive == {sw.bot[SRC_EP], sw.top[SRC_EP]})
      else $error("endpoint drives unselected pair");
   a_ep_quiet: assert property (!ep_transmit |=> ep_drive == 2'h0)
      else $error("endpoint drives while receiving");
   a_dcd_side: assert property (ctrl_q[CTRL_DCD_EN] |=>
      dcd_dplus_current == {$past(orient_q), !$past(orient_q)})
      else $error("dcd current on wrong d+");
   a_cmp_gate: assert property (!cmpen_q[0] && !flag_q[0] |=> !flag_q[0])
      else $error("disabled comparator flagged");
   a_cmp_mirror: assert property (cmp_en == $past(cmpen_q[5:0]))
      else $error("comparator enable lags");
   a_pull_mirror: assert property (pull_up == $past(pull_q[5:0]) &&
      pull_dn == $past(pull_q[PULL_DN_LSB +: 6]))
      else $error("pull select lags");
   a_uart_dir: assert property (ctrl_q[CTRL_XBAR_EN] && xbar_q[1:0] == 2'h0 |=>
      xb_pin_oe[1:0] == $past(xbar_q[XBAR_DIR_LSB +: 2]))
      else $error("crossbar direction ignored");
   a_uart_tx: assert property (ctrl_q[CTRL_XBAR_EN] && xbar_q[1:0] == 2'h0 && !xbar_q[XBAR_DIR_LSB] |=>
      core_serial_out[0] == $past(xb_s2[0]))
      else $error("channel zero not fed from pin pair zero");
   a_ls_off: assert property (ctrl_q[CTRL_LS_ANALOG] |=> xb_pin_oe[3:2] == 2'h0)
      else $error("lowspeed pins driven in analog mode");
endmodule : tcm_port_mux_ctrl
`default_nettype wire

// File: tb/tcm_cable_model.sv
// cable plug and port partner seen by the port mux control block
// assumes the bench asks for plug turns and line levels on core_clk
`timescale 1ns/1ns
`default_nettype none
module tcm_cable_model
   import tcm_pkg::*;
(
   input  wire logic       core_clk,
   input  wire logic       plug_reversed,
   input  wire logic [5:0] line_levels,
   input  wire logic [2:0] serial_levels,
   output logic            orient_flip_pin,
   output logic [5:0]      port_pin_in,
   output logic [2:0]      core_serial_in
);
   // ==========================================
   // partner levels change just after an edge, like a real far end
   initial begin
      orient_flip_pin = 1'b0;
      port_pin_in     = 6'h00;
      core_serial_in  = 3'h0;
   end
   always @(posedge core_clk) begin
      orient_flip_pin <= plug_reversed;   // reversed plug lands d+/d- on the opposite row
      port_pin_in     <= line_levels;     // digital levels passed on every edge, comparators enabled or not
      core_serial_in  <= serial_levels;
   end
endmodule : tcm_cable_model
`default_nettype wire

// File: tb/tb_top.sv
// self-checking bench for the port mux control block
// assumes an ahb-lite slave polled for hready with a bounded wait and a 10 MHz core clock
`timescale 1ns/1ns
`default_nettype none
module tb_top
   import tcm_pkg::*;
;
   logic core_clk, rstn, hsel, hwrite, hreadyout, hresp, ep_transmit, flip, ls_analog, core_irq;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0]  htrans, lowspeed_pullup, ep_drive, dcd_dplus_current, dcd_dminus_pulldown;
   logic [2:0]  hsize, core_serial_in, core_serial_out, ser;
   logic [5:0]  port_pin_in, xb_pin_in, xb_pin_out, xb_pin_oe, clamp_en, pull_up, pull_dn, cmp_en, lines;
   logic        orient_flip_pin;
   tcm_sw_s     sw;
   int          num_errors, check_count;

   tcm_port_mux_ctrl u_tcm_port_mux_ctrl (.core_clk(core_clk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .orient_flip_pin(orient_flip_pin),
      .ep_transmit(ep_transmit), .port_pin_in(port_pin_in), .xb_pin_in(xb_pin_in), .xb_pin_out(xb_pin_out),
      .xb_pin_oe(xb_pin_oe), .core_serial_in(core_serial_in), .core_serial_out(core_serial_out), .sw(sw),
      .clamp_en(clamp_en), .pull_up(pull_up), .pull_dn(pull_dn), .cmp_en(cmp_en),
      .lowspeed_pullup(lowspeed_pullup), .ep_drive(ep_drive), .dcd_dplus_current(dcd_dplus_current),
      .dcd_dminus_pulldown(dcd_dminus_pulldown), .ls_analog(ls_analog), .core_irq(core_irq));
   tcm_cable_model u_tcm_cable_model (.core_clk(core_clk), .plug_reversed(flip), .line_levels(lines),
      .serial_levels(ser), .orient_flip_pin(orient_flip_pin), .port_pin_in(port_pin_in),
      .core_serial_in(core_serial_in));

   // ==========================================
   // common helpers
   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   // no fixed latency assumed: wait for hready, bounded
   task automatic wait_rdy();
      int n;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (hreadyout !== 1'b1 && n < 50);
      if (n >= 50) chk("hready wait", 32'h0000_0001, 32'h0000_0000);
   endtask : wait_rdy
   task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
      hsel <= 1'b1; htrans <= 2'h2; haddr <= a; hwrite <= wr; hsize <= 3'h2;
      wait_rdy();
      htrans <= 2'h0; hsel <= 1'b0; hwdata <= d;
      wait_rdy();
      rd = hrdata;
      if (hresp !== 1'b0) chk("hresp", 32'h0000_0000, {31'h0, hresp});
   endtask : bus
   task automatic settle();
      repeat (6) @(posedge core_clk);
   endtask : settle

   // ==========================================
   // scenarios
   task automatic t_reset_regs();
      bus(1'b0, {24'h0, OFS_CTRL}, 32'h0);  chk("ctrl rst", 32'h0000_0000, rd);
      bus(1'b0, {24'h0, OFS_XBAR}, 32'h0);  chk("xbar rst", 32'h0000_3F3F, rd);
      bus(1'b0, {24'h0, OFS_INFO}, 32'h0);  chk("info", 32'h0005_DC11, rd);
      bus(1'b1, 32'h0000_001C, 32'hFFFF_FFFF);
      bus(1'b0, 32'h0000_001C, 32'h0);      chk("unmapped", 32'h0000_0000, rd);
   endtask : t_reset_regs
   task automatic t_bypass();
      xb_pin_in <= 6'h01; settle();
      chk("bypass hi", 32'h0000_0022, {24'h0, 2'b0, xb_pin_oe[1], 3'b0, xb_pin_out[1], 1'b0});
      xb_pin_in <= 6'h00; settle();
      chk("bypass lo", 32'h0000_0000, {31'h0, xb_pin_out[1]});
   endtask : t_bypass
   task automatic t_steer(input logic rev);
      logic [1:0] sel;
      sel = rev ? 2'b10 : 2'b01;
      flip <= rev; settle();
      chk("sw", rev ? 32'h0100_0204 : 32'h0000_0402, {7'h0, sw});
      chk("clamp", 32'h0000_000F, {26'h0, clamp_en});
      chk("pullup rx", {30'h0, sel}, {30'h0, lowspeed_pullup});
      chk("dcd src", {30'h0, sel}, {30'h0, dcd_dplus_current});
      chk("dcd pd", {30'h0, sel}, {30'h0, dcd_dminus_pulldown});
      ep_transmit <= 1'b1; settle();
      chk("pullup tx", 32'h0000_0000, {30'h0, lowspeed_pullup});
      chk("ep drive", {30'h0, ~sel}, {30'h0, ep_drive});
      ep_transmit <= 1'b0;
   endtask : t_steer
   task automatic t_compare();
      bus(1'b1, {24'h0, OFS_CMPEN}, 32'h0000_0001); settle();
      chk("cmp en", 32'h0000_0001, {26'h0, cmp_en});
      lines <= 6'h02; settle();
      chk("irq masked", 32'h0000_0000, {31'h0, core_irq});
      lines <= 6'h03;
      repeat (10) if (core_irq !== 1'b1) @(posedge core_clk);
      chk("irq", 32'h0000_0001, {31'h0, core_irq});
      bus(1'b0, {24'h0, OFS_STAT}, 32'h0); chk("flags", 32'h0000_0001, {26'h0, rd[5:0]});
      bus(1'b1, {24'h0, OFS_STAT}, 32'h0000_0001); settle();
      chk("irq clr", 32'h0000_0000, {31'h0, core_irq});
      bus(1'b1, {24'h0, OFS_CMPEN}, 32'h0000_0000);
   endtask : t_compare
   task automatic t_xbar();
      bus(1'b1, {24'h0, OFS_CTRL}, 32'h0000_0001);
      bus(1'b1, {24'h0, OFS_XBAR}, 32'h0000_023C);
      bus(1'b1, {24'h0, OFS_SEL}, 32'h0000_0007);
      xb_pin_in <= 6'h01; ser <= 3'h0; settle();
      chk("uart top", 32'h0000_0080, {24'h0, sw.top});
      chk("tx path", 32'h0000_0001, {30'h0, xb_pin_out[1], core_serial_out[0]});
      chk("dir", 32'h0000_0002, {26'h0, xb_pin_oe});
      xb_pin_in <= 6'h00; ser <= 3'h1; settle();
      chk("rx path", 32'h0000_0002, {30'h0, xb_pin_out[1], core_serial_out[0]});
      bus(1'b1, {24'h0, OFS_XBAR}, 32'h0000_3F34); settle();
      chk("ls digital", 32'h0000_000F, {26'h0, xb_pin_oe});
      bus(1'b1, {24'h0, OFS_CTRL}, 32'h0000_0009); settle();
      chk("ls analog", 32'h0000_0004, {29'h0, ls_analog, xb_pin_oe[3:2]});
   endtask : t_xbar
   task automatic t_pulls();
      bus(1'b1, {24'h0, OFS_PULL}, 32'h0000_2A15); settle();
      chk("pulls", 32'h0000_2A15, {18'h0, pull_dn, 2'b0, pull_up});
   endtask : t_pulls

   task automatic report_and_stop();
      $display("checks %0d errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : report_and_stop

   initial begin
      rstn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0; hsize = 3'h2;
      hwdata = 32'h0; ep_transmit = 1'b0; xb_pin_in = 6'h00; flip = 1'b0; lines = 6'h00; ser = 3'h0;
      num_errors = 0; check_count = 0;
      repeat (5) @(posedge core_clk);
      rstn <= 1'b1;
      @(posedge core_clk);
      t_reset_regs();
      t_bypass();
      bus(1'b1, {24'h0, OFS_CTRL}, 32'h0000_0006);
      bus(1'b1, {24'h0, OFS_SEL}, 32'h0000_0021);
      t_steer(1'b0);
      t_steer(1'b1);
      t_steer(1'b0);
      t_compare();
      t_pulls();
      t_xbar();
      report_and_stop();
   end
   initial begin
      #(3000 * 100);
      num_errors++;
      report_and_stop();
   end
endmodule : tb_top
`default_nettype wire
